// file: common/pos_pkg.sv
// Constants, setting codes and reset values for the position output stage
//
// Behaviour
// - Setting writes are refused unless the unit is in program mode.
// - Position at or above upper limit actuates upper relay and its indicator.
// - Upper limit accepts 0 to 999.999 inches, defaults to 999.999.
// - Position at or below lower limit actuates lower relay; default 0.000.
// - Polarity 0: relays energized normally; 1: energized on limit or error.
// - Override code 2110 releases limit relays actuated by overtravel.
// - Reaching a limit again re-actuates its relay; a new override is needed.
// - Digital word format: 0 binary, 1 BCD, 2 Gray.
// - Handshake: 0 latch method (default), 1 synchronous edge method.
// - Synchronous mode updates the word only on a handshake input transition.
// - Synchronous mode holds the word while no handshake transitions occur.
// - Latch mode updates while latch input low, freezes while it is high.
// - Latch mode resumes current position as soon as latch is released.
// - Output polarity: 0 low-true, 1 high-true (default).
// - On failure: 0 all outputs off, 1 all on, 2 hold last valid.
// - Two analog channels, each selecting position (0) or velocity (1).
// - Velocity arrives in RPM or length units per second per sensor type.
// - Each channel drives voltage and current; setting picks which is scaled.
// - Output points lie within -10 to +10 V or 0 to 20 mA.
// - Linear map between programmed points, clamped below min and above max.
package pos_pkg;

	localparam int POS_W = 20;
	localparam int SRC_W = 21;
	localparam int AOUT_W = 16;
	localparam int DIG_W = 24;
	localparam int CLK_HZ = 10000000;

	// Position in thousandths of an inch
	localparam logic [POS_W-1:0] POS_MAX = 20'hF423F;
	localparam logic [POS_W-1:0] UPPER_RST = 20'hF423F;
	localparam logic [POS_W-1:0] LOWER_RST = 20'h00000;

	// Analog points: millivolts or microamps
	localparam logic signed [AOUT_W-1:0] VOLT_MAX = 16'sh2710;
	localparam logic signed [AOUT_W-1:0] VOLT_MIN = -16'sh2710;
	localparam logic signed [AOUT_W-1:0] CURR_MAX = 16'sh4E20;
	localparam logic signed [AOUT_W-1:0] CURR_MIN = 16'sh0000;

	localparam logic [31:0] OVERRIDE_CODE = 32'h0000083E;

	// Reader settling time after a handshake edge; the device does not wait on it
	localparam int SETTLE_NS = 100000;
	localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1000000) + 999) / 1000;

	// Setting select codes
	localparam logic [7:0] SEL_UPPER = 8'h00;
	localparam logic [7:0] SEL_LOWER = 8'h01;
	localparam logic [7:0] SEL_RELAY_POL = 8'h02;
	localparam logic [7:0] SEL_OVERRIDE = 8'h03;
	localparam logic [7:0] SEL_FORMAT = 8'h10;
	localparam logic [7:0] SEL_HSHAKE = 8'h11;
	localparam logic [7:0] SEL_LEVEL = 8'h12;
	localparam logic [7:0] SEL_FAIL = 8'h13;
	// Analog channel n at 8'h20 + 8'h10*n, item in low nibble
	localparam logic [2:0] SEL_ANA_HI = 3'h1;
	localparam logic [3:0] ANA_SRC = 4'h0;
	localparam logic [3:0] ANA_TYPE = 4'h1;
	localparam logic [3:0] ANA_MIN_SRC = 4'h2;
	localparam logic [3:0] ANA_MIN_OUT = 4'h3;
	localparam logic [3:0] ANA_MAX_SRC = 4'h4;
	localparam logic [3:0] ANA_MAX_OUT = 4'h5;

	localparam logic [1:0] FMT_BIN = 2'h0;
	localparam logic [1:0] FMT_BCD = 2'h1;
	localparam logic [1:0] FMT_GRAY = 2'h2;
	localparam logic [1:0] FAIL_OFF = 2'h0;
	localparam logic [1:0] FAIL_ON = 2'h1;
	localparam logic [1:0] FAIL_HOLD = 2'h2;

	localparam logic RELAY_POL_RST = 1'b0;
	localparam logic HSHAKE_RST = 1'b0;
	localparam logic LEVEL_RST = 1'b1;
	localparam logic [1:0] FORMAT_RST = 2'h0;
	localparam logic [1:0] FAIL_RST = 2'h0;

endpackage

// file: rtl/pos_scaler.sv
// Linear, clamped analog scaler for one output channel
`timescale 1ns/1ps
`default_nettype none
module pos_scaler import pos_pkg::*; #(
	parameter int SW = SRC_W,
	parameter int OW = AOUT_W
) (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic signed [SW-1:0] src,
	input wire logic signed [SW-1:0] min_src,
	input wire logic signed [SW-1:0] max_src,
	input wire logic signed [OW-1:0] min_out,
	input wire logic signed [OW-1:0] max_out,
	input wire logic use_current,
	output logic signed [OW-1:0] volt_out,
	output logic signed [OW-1:0] curr_out
);

	localparam int PW = SW + OW + 2;

	logic signed [SW:0] d_src;
	logic signed [SW:0] span_src;
	logic signed [OW:0] span_out;
	logic signed [PW-1:0] prod;
	logic signed [PW-1:0] quot;
	logic signed [OW-1:0] scaled;

	always_comb begin
		d_src = {src[SW-1], src} - {min_src[SW-1], min_src};
		span_src = {max_src[SW-1], max_src} - {min_src[SW-1], min_src};
		span_out = {max_out[OW-1], max_out} - {min_out[OW-1], min_out};
		prod = d_src * span_out;
		quot = '0;
		if (src <= min_src) begin
			scaled = min_out;
		end else if (src >= max_src) begin
			scaled = max_out;
		end else begin
			quot = prod / PW'(span_src);
			scaled = OW'(min_out + OW'(quot));
		end
	end

	// Both outputs are driven; the unscaled one rests at zero
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			volt_out <= '0;
			curr_out <= '0;
		end else begin
			volt_out <= use_current ? '0 : scaled;
			curr_out <= use_current ? scaled : '0;
		end
	end

endmodule // pos_scaler
`default_nettype wire

// file: rtl/pos_output_stage.sv
// Limit relays, parallel position port and two analog channels
`timescale 1ns/1ps
`default_nettype none
module pos_output_stage import pos_pkg::*; (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic program_mode,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_sel,
	input wire logic [31:0] cfg_data,
	output logic cfg_refused,
	input wire logic [POS_W-1:0] position,
	input wire logic signed [POS_W-1:0] velocity,
	input wire logic fault,
	input wire logic latch_pin,
	input wire logic hshake_pin,
	output logic upper_relay,
	output logic lower_relay,
	output logic upper_led,
	output logic lower_led,
	output logic [DIG_W-1:0] dig_out,
	output logic signed [AOUT_W-1:0] volt_out0,
	output logic signed [AOUT_W-1:0] curr_out0,
	output logic signed [AOUT_W-1:0] volt_out1,
	output logic signed [AOUT_W-1:0] curr_out1
);

	////////////////////////////////////////////////////////////////////////
	// Settings

	logic [POS_W-1:0] upper_reg;
	logic [POS_W-1:0] lower_reg;
	logic relay_pol_reg;
	logic [1:0] format_reg;
	logic hshake_reg;
	logic level_reg;
	logic [1:0] fail_reg;
	logic ana_src_reg [2];
	logic ana_type_reg [2];
	logic signed [SRC_W-1:0] ana_min_src_reg [2];
	logic signed [SRC_W-1:0] ana_max_src_reg [2];
	logic signed [AOUT_W-1:0] ana_min_out_reg [2];
	logic signed [AOUT_W-1:0] ana_max_out_reg [2];

	logic wr_ok;
	logic override_cmd;
	logic ana_hit;
	logic ana_ch;
	logic pos_ok;
	logic out_ok;
	logic signed [31:0] sdata;

	assign wr_ok = cfg_wr && program_mode;
	assign ana_hit = (cfg_sel[7:5] == SEL_ANA_HI);
	assign ana_ch = cfg_sel[4];
	assign sdata = cfg_data;
	assign pos_ok = (cfg_data <= 32'(POS_MAX));
	assign out_ok = ana_type_reg[ana_ch] ?
		(sdata >= 32'(CURR_MIN) && sdata <= 32'(CURR_MAX)) :
		(sdata >= 32'(VOLT_MIN) && sdata <= 32'(VOLT_MAX));
	assign override_cmd = wr_ok && cfg_sel == SEL_OVERRIDE && cfg_data == OVERRIDE_CODE;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			upper_reg <= UPPER_RST;
			lower_reg <= LOWER_RST;
			relay_pol_reg <= RELAY_POL_RST;
			format_reg <= FORMAT_RST;
			hshake_reg <= HSHAKE_RST;
			level_reg <= LEVEL_RST;
			fail_reg <= FAIL_RST;
			cfg_refused <= 1'b0;
		end else begin
			cfg_refused <= cfg_wr && !program_mode;
			if (wr_ok) begin
				if (cfg_sel == SEL_UPPER) begin
					if (pos_ok) begin
						upper_reg <= cfg_data[POS_W-1:0];
					end else begin
						cfg_refused <= 1'b1;
					end
				end else if (cfg_sel == SEL_LOWER) begin
					if (pos_ok) begin
						lower_reg <= cfg_data[POS_W-1:0];
					end else begin
						cfg_refused <= 1'b1;
					end
				end else if (cfg_sel == SEL_RELAY_POL) begin
					relay_pol_reg <= cfg_data[0];
				end else if (cfg_sel == SEL_FORMAT) begin
					if (cfg_data <= 32'(FMT_GRAY)) begin
						format_reg <= cfg_data[1:0];
					end else begin
						cfg_refused <= 1'b1;
					end
				end else if (cfg_sel == SEL_HSHAKE) begin
					hshake_reg <= cfg_data[0];
				end else if (cfg_sel == SEL_LEVEL) begin
					level_reg <= cfg_data[0];
				end else if (cfg_sel == SEL_FAIL) begin
					if (cfg_data <= 32'(FAIL_HOLD)) begin
						fail_reg <= cfg_data[1:0];
					end else begin
						cfg_refused <= 1'b1;
					end
				end else if (cfg_sel == SEL_OVERRIDE) begin
					cfg_refused <= !override_cmd;
				end else if (!ana_hit) begin
					cfg_refused <= 1'b1;
				end
			end
		end
	end

	// Analog channel settings
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			for (int i = 0; i < 2; i++) begin
				ana_src_reg[i] <= 1'b0;
				ana_type_reg[i] <= 1'b0;
				ana_min_src_reg[i] <= '0;
				ana_max_src_reg[i] <= '0;
				ana_min_out_reg[i] <= '0;
				ana_max_out_reg[i] <= '0;
			end
		end else if (wr_ok && ana_hit) begin
			if (cfg_sel[3:0] == ANA_SRC) begin
				ana_src_reg[ana_ch] <= cfg_data[0];
			end else if (cfg_sel[3:0] == ANA_TYPE) begin
				ana_type_reg[ana_ch] <= cfg_data[0];
			end else if (cfg_sel[3:0] == ANA_MIN_SRC) begin
				ana_min_src_reg[ana_ch] <= cfg_data[SRC_W-1:0];
			end else if (cfg_sel[3:0] == ANA_MAX_SRC) begin
				ana_max_src_reg[ana_ch] <= cfg_data[SRC_W-1:0];
			end else if (cfg_sel[3:0] == ANA_MIN_OUT && out_ok) begin
				ana_min_out_reg[ana_ch] <= cfg_data[AOUT_W-1:0];
			end else if (cfg_sel[3:0] == ANA_MAX_OUT && out_ok) begin
				ana_max_out_reg[ana_ch] <= cfg_data[AOUT_W-1:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Limit relays

	logic upper_hit;
	logic lower_hit;
	logic upper_ovr_reg;
	logic lower_ovr_reg;
	logic upper_act;
	logic lower_act;

	assign upper_hit = (position >= upper_reg);
	assign lower_hit = (position <= lower_reg);
	assign upper_act = upper_hit && !upper_ovr_reg;
	assign lower_act = lower_hit && !lower_ovr_reg;

	// Override holds only while the limit stays hit; leaving it re-arms
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			upper_ovr_reg <= 1'b0;
			lower_ovr_reg <= 1'b0;
		end else begin
			upper_ovr_reg <= upper_hit && (upper_ovr_reg || override_cmd);
			lower_ovr_reg <= lower_hit && (lower_ovr_reg || override_cmd);
		end
	end

	// Errors always actuate; override frees only the relays, indicators keep showing the limit
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			upper_relay <= !RELAY_POL_RST;
			lower_relay <= !RELAY_POL_RST;
			upper_led <= 1'b0;
			lower_led <= 1'b0;
		end else begin
			upper_relay <= relay_pol_reg ~^ (upper_act || fault);
			lower_relay <= relay_pol_reg ~^ (lower_act || fault);
			upper_led <= upper_hit;
			lower_led <= lower_hit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Parallel position port

	function automatic logic [DIG_W-1:0] to_bcd(input logic [POS_W-1:0] b);
		logic [DIG_W+POS_W-1:0] s;
		begin
			s = {{DIG_W{1'b0}}, b};
			for (int i = 0; i < POS_W; i++) begin
				for (int j = 0; j < DIG_W / 4; j++) begin
					if (s[POS_W+4*j +: 4] >= 4'h5) begin
						s[POS_W+4*j +: 4] = s[POS_W+4*j +: 4] + 4'h3;
					end
				end
				s = s << 1;
			end
			to_bcd = s[DIG_W+POS_W-1:POS_W];
		end
	endfunction

	logic latch_s1_reg;
	logic latch_s2_reg;
	logic hs_s1_reg;
	logic hs_s2_reg;
	logic hs_s3_reg;
	logic [DIG_W-1:0] enc;
	logic [DIG_W-1:0] word_reg;
	logic [DIG_W-1:0] word_next;
	logic upd;

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			latch_s1_reg <= 1'b0;
			latch_s2_reg <= 1'b0;
			hs_s1_reg <= 1'b0;
			hs_s2_reg <= 1'b0;
			hs_s3_reg <= 1'b0;
		end else begin
			latch_s1_reg <= latch_pin;
			latch_s2_reg <= latch_s1_reg;
			hs_s1_reg <= hshake_pin;
			hs_s2_reg <= hs_s1_reg;
			hs_s3_reg <= hs_s2_reg;
		end
	end

	always_comb begin
		if (format_reg == FMT_BCD) begin
			enc = to_bcd(position);
		end else if (format_reg == FMT_GRAY) begin
			enc = DIG_W'(position ^ (position >> 1));
		end else begin
			enc = DIG_W'(position);
		end
		if (hshake_reg) begin
			upd = hs_s2_reg ^ hs_s3_reg;
		end else begin
			upd = !latch_s2_reg;
		end
		if (fault && fail_reg == FAIL_OFF) begin
			word_next = '0;
		end else if (fault && fail_reg == FAIL_ON) begin
			word_next = '1;
		end else if (fault || !upd) begin
			word_next = word_reg;
		end else begin
			word_next = enc;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			word_reg <= '0;
			dig_out <= LEVEL_RST ? '0 : '1;
		end else begin
			word_reg <= word_next;
			dig_out <= level_reg ? word_next : ~word_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Analog channels

	logic signed [AOUT_W-1:0] volt_w [2];
	logic signed [AOUT_W-1:0] curr_w [2];

	generate
		for (genvar c = 0; c < 2; c++) begin : g_ana
			logic signed [SRC_W-1:0] src;
			// Velocity already carries RPM or length per second
			assign src = ana_src_reg[c] ? SRC_W'(velocity) :
				$signed({1'b0, position});
			pos_scaler #(
				.SW(SRC_W),
				.OW(AOUT_W)
			) u_scaler (
				.sys_clk(sys_clk),
				.nrst(nrst),
				.src(src),
				.min_src(ana_min_src_reg[c]),
				.max_src(ana_max_src_reg[c]),
				.min_out(ana_min_out_reg[c]),
				.max_out(ana_max_out_reg[c]),
				.use_current(ana_type_reg[c]),
				.volt_out(volt_w[c]),
				.curr_out(curr_w[c])
			);
		end
	endgenerate

	assign volt_out0 = volt_w[0];
	assign curr_out0 = curr_w[0];
	assign volt_out1 = volt_w[1];
	assign curr_out1 = curr_w[1];

endmodule // pos_output_stage
`default_nettype wire

// file: bench/pos_output_stage_assertions.sv
// Port-level assertions for the position output stage
`timescale 1ns/1ps
`default_nettype none
module pos_output_stage_assertions import pos_pkg::*; (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic program_mode,
	input wire logic cfg_wr,
	input wire logic [7:0] cfg_sel,
	input wire logic [31:0] cfg_data,
	input wire logic cfg_refused,
	input wire logic [POS_W-1:0] position,
	input wire logic fault,
	input wire logic latch_pin,
	input wire logic hshake_pin,
	input wire logic upper_relay,
	input wire logic lower_relay,
	input wire logic upper_led,
	input wire logic lower_led,
	input wire logic [DIG_W-1:0] dig_out
);
	logic [POS_W-1:0] up_reg;
	logic [POS_W-1:0] lo_reg;
	logic pol_reg;
	logic hs_reg;
	logic acc;
	assign acc = cfg_wr && program_mode;
	// Shadow of the settings the stage has accepted
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			up_reg <= UPPER_RST;
			lo_reg <= LOWER_RST;
			pol_reg <= RELAY_POL_RST;
			hs_reg <= HSHAKE_RST;
		end else if (acc) begin
			if (cfg_sel == SEL_UPPER && cfg_data <= 32'h000F423F) up_reg <= cfg_data[POS_W-1:0];
			if (cfg_sel == SEL_LOWER && cfg_data <= 32'h000F423F) lo_reg <= cfg_data[POS_W-1:0];
			if (cfg_sel == SEL_RELAY_POL) pol_reg <= cfg_data[0];
			if (cfg_sel == SEL_HSHAKE) hs_reg <= cfg_data[0];
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	a_refuse_locked: assert property (cfg_wr && !program_mode |=> cfg_refused)
		else $error("write outside program mode not refused");
	a_upper_hit: assert property (position >= up_reg |=> upper_led)
		else $error("upper indicator missing");
	a_upper_clear: assert property (position < up_reg |=> !upper_led)
		else $error("upper indicator without limit");
	a_lower_hit: assert property (position <= lo_reg |=> lower_led)
		else $error("lower indicator missing");
	a_upper_range: assert property (acc && cfg_sel == SEL_UPPER && cfg_data > 32'h000F423F |=> cfg_refused)
		else $error("upper limit out of range accepted");
	a_format_range: assert property (acc && cfg_sel == SEL_FORMAT && cfg_data > 32'h00000002 |=> cfg_refused)
		else $error("bad format accepted");
	a_fault_relay: assert property (fault |=> upper_relay == pol_reg && lower_relay == pol_reg)
		else $error("relays not in error state");
	a_sync_hold: assert property ((hs_reg && !fault && $stable(hshake_pin)) [*5] |-> $stable(dig_out))
		else $error("word moved without handshake edge");
	a_latch_freeze: assert property ((!hs_reg && !fault && latch_pin) [*5] |-> $stable(dig_out))
		else $error("word moved while latched");
endmodule // pos_output_stage_assertions
`default_nettype wire

// file: bench/pos_plc_reader.sv
// PLC input card model: drives latch and handshake, reads the word after settling
`timescale 1ns/1ps
`default_nettype none
module pos_plc_reader import pos_pkg::*; (
	input wire logic sys_clk,
	input wire logic [DIG_W-1:0] dig_out,
	output logic latch_pin,
	output logic hshake_pin
);
	initial begin
		latch_pin = 1'b0;
		hshake_pin = 1'b0;
	end
	task automatic read_word(output logic [DIG_W-1:0] w);
		repeat (SETTLE_CYC) @(posedge sys_clk);
		@(negedge sys_clk);
		w = dig_out;
	endtask
	task automatic set_latch(input logic v, output logic [DIG_W-1:0] w);
		@(negedge sys_clk);
		latch_pin = v;
		read_word(w);
	endtask
	task automatic toggle(output logic [DIG_W-1:0] w);
		@(negedge sys_clk);
		hshake_pin = !hshake_pin;
		read_word(w);
	endtask
endmodule // pos_plc_reader
`default_nettype wire

// file: bench/pos_output_stage_bench.sv
// Self-checking bench for the position output stage
`timescale 1ns/1ps
`default_nettype none
module pos_output_stage_bench import pos_pkg::*;;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic program_mode = 1'b1;
	logic cfg_wr = 1'b0;
	logic [7:0] cfg_sel = 8'h00;
	logic [31:0] cfg_data = 32'h0;
	logic [POS_W-1:0] position = 20'h1E240;
	logic signed [POS_W-1:0] velocity = 20'sh0;
	logic fault = 1'b0;
	logic cfg_refused, latch_pin, hshake_pin, upper_relay, lower_relay, upper_led, lower_led;
	logic [DIG_W-1:0] dig_out;
	logic [DIG_W-1:0] w;
	logic signed [AOUT_W-1:0] volt_out0, curr_out0, volt_out1, curr_out1;
	int errors = 0;
	int samples_checked = 0;
	localparam logic [31:0] AV [12] = '{32'h0, 32'h0, 32'h1F4, 32'h7D0, 32'h7D0, 32'h1F40,
		32'h1, 32'h1, 32'h0, 32'hFA0, 32'h3E8, 32'h4E20};
	pos_output_stage dut (.sys_clk, .nrst, .program_mode, .cfg_wr, .cfg_sel, .cfg_data, .cfg_refused,
		.position, .velocity, .fault, .latch_pin, .hshake_pin, .upper_relay, .lower_relay, .upper_led,
		.lower_led, .dig_out, .volt_out0, .curr_out0, .volt_out1, .curr_out1);
	pos_plc_reader rdr (.sys_clk, .dig_out, .latch_pin, .hshake_pin);
	always #50 sys_clk = ~sys_clk;
	////////////////////////////////////////////////////////////////
	function automatic logic [DIG_W-1:0] enc(input logic [1:0] f, input logic [POS_W-1:0] p);
		logic [DIG_W-1:0] b;
		b = '0;
		if (f == FMT_BIN) b = {4'h0, p};
		else if (f == FMT_GRAY) b = {4'h0, p ^ (p >> 1)};
		else for (int i = 0; i < 6; i++) b[4*i +: 4] = 4'((p / (10 ** i)) % 10);
		return b;
	endfunction
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task tick(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	task cfg(input logic [7:0] s, input logic [31:0] d, input logic r);
		@(negedge sys_clk);
		cfg_wr = 1'b1;
		cfg_sel = s;
		cfg_data = d;
		@(negedge sys_clk);
		cfg_wr = 1'b0;
		chk("cfg_refused", r, cfg_refused);
	endtask
	task pos_to(input logic [POS_W-1:0] p);
		@(negedge sys_clk);
		position = p;
		tick(3);
	endtask
	task fault_to(input logic v);
		@(negedge sys_clk);
		fault = v;
		tick(3);
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task t_refuse;
		program_mode = 1'b0;
		cfg(SEL_UPPER, 32'h1F4, 1'b1);
		pos_to(20'h00258);
		chk("upper_led", 1'b0, upper_led);
		program_mode = 1'b1;
		cfg(SEL_UPPER, 32'h000F4240, 1'b1);
		cfg(SEL_FORMAT, 32'h3, 1'b1);
		cfg(SEL_FAIL, 32'h3, 1'b1);
		cfg(SEL_UPPER, 32'h000F423F, 1'b0);
		pos_to(20'hF423F);
		chk("upper_led", 1'b1, upper_led);
		$display("test refuse done");
	endtask
	task t_limits;
		cfg(SEL_UPPER, 32'h1F4, 1'b0);
		pos_to(20'h001F4);
		chk("upper_led", 1'b1, upper_led);
		chk("upper_relay", 1'b0, upper_relay);
		pos_to(20'h001F3);
		chk("upper_led", 1'b0, upper_led);
		chk("upper_relay", 1'b1, upper_relay);
		cfg(SEL_LOWER, 32'h64, 1'b0);
		pos_to(20'h00064);
		chk("lower_led", 1'b1, lower_led);
		chk("lower_relay", 1'b0, lower_relay);
		cfg(SEL_RELAY_POL, 32'h1, 1'b0);
		tick(2);
		chk("lower_relay", 1'b1, lower_relay);
		pos_to(20'h000C8);
		chk("lower_relay", 1'b0, lower_relay);
		fault_to(1'b1);
		chk("relays", 2'b11, {upper_relay, lower_relay});
		fault_to(1'b0);
		$display("test limits done");
	endtask
	task t_override;
		cfg(SEL_RELAY_POL, 32'h0, 1'b0);
		pos_to(20'h001F4);
		cfg(SEL_OVERRIDE, 32'h83F, 1'b1);
		tick(2);
		chk("upper_relay", 1'b0, upper_relay);
		cfg(SEL_OVERRIDE, OVERRIDE_CODE, 1'b0);
		tick(2);
		chk("upper_relay", 1'b1, upper_relay);
		chk("upper_led", 1'b1, upper_led);
		pos_to(20'h0012C);
		pos_to(20'h001F4);
		chk("upper_relay", 1'b0, upper_relay);
		$display("test override done");
	endtask
	task t_digital;
		logic [POS_W-1:0] p0;
		for (int f = 0; f < 3; f++) begin
			cfg(SEL_FORMAT, 32'(f), 1'b0);
			pos_to(20'h03039 + 20'(f));
			chk("dig_out", enc(2'(f), position), dig_out);
		end
		cfg(SEL_LEVEL, 32'h0, 1'b0);
		tick(2);
		w = ~enc(FMT_GRAY, position);
		chk("dig_out", w, dig_out);
		cfg(SEL_LEVEL, 32'h1, 1'b0);
		cfg(SEL_FORMAT, 32'h0, 1'b0);
		p0 = position;
		rdr.set_latch(1'b1, w);
		chk("latched", enc(FMT_BIN, p0), w);
		pos_to(20'h00400);
		rdr.read_word(w);
		chk("frozen", enc(FMT_BIN, p0), w);
		rdr.set_latch(1'b0, w);
		chk("released", enc(FMT_BIN, position), w);
		cfg(SEL_HSHAKE, 32'h1, 1'b0);
		p0 = position;
		pos_to(20'h00555);
		tick(20);
		chk("sync held", enc(FMT_BIN, p0), dig_out);
		rdr.toggle(w);
		chk("sync rise", enc(FMT_BIN, position), w);
		pos_to(20'h00666);
		rdr.toggle(w);
		chk("sync fall", enc(FMT_BIN, position), w);
		fault_to(1'b1);
		chk("fail off", 32'h0, dig_out);
		cfg(SEL_FAIL, 32'h1, 1'b0);
		tick(2);
		chk("fail on", 32'hFFFFFF, dig_out);
		fault_to(1'b0);
		cfg(SEL_HSHAKE, 32'h0, 1'b0);
		cfg(SEL_FAIL, 32'h2, 1'b0);
		p0 = position;
		fault_to(1'b1);
		pos_to(20'h00777);
		chk("fail hold", enc(FMT_BIN, p0), dig_out);
		fault_to(1'b0);
		chk("recovered", enc(FMT_BIN, position), dig_out);
		$display("test digital done");
	endtask
	task t_analog;
		for (int i = 0; i < 12; i++) cfg(8'h20 + 8'(i / 6 * 16 + i % 6), AV[i], 1'b0);
		pos_to(20'h00190);
		chk("volt_out0", 32'h7D0, volt_out0);
		pos_to(20'h004E2);
		chk("volt_out0", 32'h1388, volt_out0);
		pos_to(20'h00BB8);
		chk("volt_out0", 32'h1F40, volt_out0);
		chk("curr_out0", 32'h0, curr_out0);
		velocity = 20'sh001F4;
		tick(3);
		chk("curr_out1", 32'h2EE0, curr_out1);
		chk("volt_out1", 32'h0, volt_out1);
		velocity = 20'sh007D0;
		tick(3);
		chk("curr_out1", 32'h4E20, curr_out1);
		cfg(8'h25, 32'h2EE0, 1'b0);
		tick(2);
		chk("volt_out0", 32'h1F40, volt_out0);
		program_mode = 1'b0;
		cfg(8'h25, 32'h1770, 1'b1);
		tick(2);
		chk("volt_out0", 32'h1F40, volt_out0);
		program_mode = 1'b1;
		$display("test analog done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		tick(2);
		nrst = 1'b1;
		tick(3);
		chk("relays", 2'b11, {upper_relay, lower_relay});
		chk("leds", 2'b00, {upper_led, lower_led});
		chk("dig_out", enc(FMT_BIN, position), dig_out);
		t_refuse;
		t_limits;
		t_override;
		t_digital;
		t_analog;
		conclude;
	end
	// Run needs about 5200 cycles; allow roughly four times that
	initial begin
		#2000000;
		errors++;
		$display("[FAIL] watchdog expected finish seen timeout");
		conclude;
	end
endmodule // pos_output_stage_bench
bind pos_output_stage pos_output_stage_assertions chk_i (.sys_clk, .nrst, .program_mode, .cfg_wr, .cfg_sel,
	.cfg_data, .cfg_refused, .position, .fault, .latch_pin, .hshake_pin, .upper_relay, .lower_relay,
	.upper_led, .lower_led, .dig_out);
`default_nettype wire
